// File: core/ttm_pkg.sv
package ttm_pkg;

   // ************************************************************
   // Register port
   // ************************************************************
   localparam int          ADDR_W     = 8;
   localparam int          DATA_W     = 32;
   localparam logic [7:0]  REG_STATUS = 8'h00;
   localparam logic [7:0]  REG_CTRL   = 8'h04;

   // ************************************************************
   // Status word bit positions
   // ************************************************************
   localparam int ST_ONLINE  = 0;
   localparam int ST_LOADED  = 1;
   localparam int ST_BUSY    = 2;
   localparam int ST_WRRDY   = 3;
   localparam int ST_TEST    = 4;
   localparam int ST_NORMAL  = 5;
   localparam int ST_FAST    = 6;
   localparam int ST_REVERSE = 7;
   localparam int ST_LDFF    = 8;

   // ************************************************************
   // Write test pattern timing
   // ************************************************************
   localparam int CLK_PERIOD_NS  = 20;
   localparam int TEST_STROBE_NS = 2000;
   localparam int TEST_STROBE_CYC =
      (TEST_STROBE_NS / CLK_PERIOD_NS < 1) ? 1 : TEST_STROBE_NS / CLK_PERIOD_NS;
   localparam int CTRL_DIV_W = 16;
   localparam logic [CTRL_DIV_W-1:0] CTRL_RST = CTRL_DIV_W'(TEST_STROBE_CYC);

   typedef enum logic [2:0]
   {
      S_UNLOADED,
      S_LOAD,
      S_READY,
      S_REWIND,
      S_UNWIND
   } ttm_state_t;

endpackage

// File: core/ttm_transport.sv
`timescale 1ns/1ps
// How it works
// - Interface motion commands act only when online, selected and in ready state.
// - All motion leaves as run normal, run fast and reverse select lines.
// - Front load button sets the load flip-flop and runs tape forward normally.
// - Tape running status follows the ramp stage activity.
// - Write ready needs no file protect, not busy, and no reverse.
// - Busy is high during load point search and during any rewind.
// - Write ready turns on write and erase drivers and the write lamp.
// - Unit selected is online AND select; it gates the amplifiers.
// - Loaded, not rewinding, no write ready: read lamp lights.
// - Broken tape drops all servo drive and write ready at once.
// - Tape end marker only reports; the controller ends writes.
// - Interface rewind after a write returns tape to load point.
// - An interface rewind stops at the load point unless tension is lost first.
// - Online clears by command or button; offline rewind at load point unwinds.
// - Test panel works only offline with its stop button pressed.
// - Test mode button then enables the other test buttons.
// - Test mode runs forward or reverse at normal or fast speed.
// - Test write emits an all-ones word on every track, crystal timed.
// - Load sequence runs forward until the load point, then stops.
// - Front load and rewind buttons are ignored while online.
// - A rewind runs on until load point or loss of tension; an unwind from load point runs on until loss of tension.
module ttm_transport
#(
   parameter int TRACKS = 9
)
(
   input  wire logic                       ref_clk,
   input  wire logic                       rst_n,
   input  wire logic [ttm_pkg::ADDR_W-1:0] bus_addr,
   input  wire logic [ttm_pkg::DATA_W-1:0] bus_wdata,
   input  wire logic                       bus_wr,
   input  wire logic                       bus_rd,
   output logic      [ttm_pkg::DATA_W-1:0] bus_rdata,
   input  wire logic                       if_select,
   input  wire logic                       if_run,
   input  wire logic                       if_reverse,
   input  wire logic                       if_rewind,
   input  wire logic                       if_offline,
   input  wire logic                       load_btn,
   input  wire logic                       online_btn,
   input  wire logic                       rewind_btn,
   input  wire logic                       tp_stop,
   input  wire logic                       tp_test,
   input  wire logic                       tp_fwd,
   input  wire logic                       tp_rev,
   input  wire logic                       tp_fast,
   input  wire logic                       tp_write,
   input  wire logic                       file_protect,
   input  wire logic                       load_point,
   input  wire logic                       tape_end_marker,
   input  wire logic                       broken_tape,
   input  wire logic                       tension_lost,
   input  wire logic                       ramp_active,
   output logic                            run_normal_cmd,
   output logic                            run_fast_cmd,
   output logic                            reverse_select_cmd,
   output logic                            servo_enable,
   output logic                            tape_running,
   output logic                            busy,
   output logic                            online,
   output logic                            rewinding,
   output logic                            load_point_out,
   output logic                            tape_end_out,
   output logic                            load_lamp,
   output logic                            write_ready,
   output logic                            write_drive_on,
   output logic                            erase_drive_on,
   output logic                            write_lamp,
   output logic                            read_lamp,
   output logic                            unit_selected,
   output logic                            amp_write_en,
   output logic                            amp_read_en,
   output logic                            test_mode,
   output logic                            test_strobe,
   output logic      [TRACKS-1:0]          test_data
);
   import ttm_pkg::*;

   if (TRACKS < 1 || TRACKS > DATA_W)
   begin : g_chk
      $error("TRACKS out of range");
   end

   // ************************************************************
   // State and registers
   // ************************************************************
   ttm_state_t            state_q;
   ttm_state_t            state_d;
   logic                  load_q;
   logic                  load_d;
   logic                  online_q;
   logic                  online_d;
   logic                  test_q;
   logic                  norm_q;
   logic                  norm_d;
   logic                  fast_q;
   logic                  fast_d;
   logic                  rev_q;
   logic                  rev_d;
   logic [CTRL_DIV_W-1:0] div_q;
   logic [CTRL_DIV_W-1:0] cnt_q;
   logic                  strobe_q;
   logic [TRACKS-1:0]     tdata_q;
   logic [DATA_W-1:0]     rdata_q;

   // Motion in progress; a new speed is only taken from rest
   function automatic logic moving(input logic n, input logic f);
      return n | f;
   endfunction

   // ************************************************************
   // Interlocks
   // ************************************************************
   wire at_ready  = (state_q == S_READY);
   wire sel_w     = online_q & if_select;
   wire if_ok     = sel_w & at_ready & ~broken_tape;
   wire panel_ok  = ~online_q & ~broken_tape;
   wire tp_ok     = ~online_q & tp_stop;
   wire test_go   = test_q & tp_ok & at_ready & ~broken_tape;
   wire busy_w    = (state_q == S_LOAD) | (state_q == S_REWIND)
                  | (state_q == S_UNWIND);
   wire rew_w     = (state_q == S_REWIND) | (state_q == S_UNWIND);
   wire loaded_w  = at_ready;
   wire tp_req    = test_go & (tp_fwd | tp_rev);
   wire if_req    = if_ok & if_run;
   wire want_run  = if_req | tp_req;
   wire want_rev  = if_req ? if_reverse : (tp_rev & ~tp_fwd);
   wire want_fast = tp_req & tp_fast;
   wire wr_ok     = loaded_w & ~file_protect & ~busy_w & ~rev_q
                  & ~broken_tape;
   wire tw_active = test_go & tp_write & wr_ok & norm_q;
   wire div_hit   = (cnt_q + 1'b1 >= div_q);

   // ************************************************************
   // Sequencer
   // ************************************************************
   always_comb
   begin
      state_d = state_q;
      load_d  = load_q;
      norm_d  = 1'b0;
      fast_d  = 1'b0;
      rev_d   = 1'b0;
      case (state_q)
         S_UNLOADED:
         begin
            if (panel_ok & load_btn & ~load_q)
            begin
               state_d = S_LOAD;
               load_d  = 1'b1;
               norm_d  = 1'b1;
            end
         end
         S_LOAD:
         begin
            norm_d = 1'b1;
            if (panel_ok & rewind_btn)
            begin
               state_d = S_REWIND;
               norm_d  = 1'b0;
               fast_d  = 1'b1;
               rev_d   = 1'b1;
            end
            else if (load_point)
            begin
               state_d = S_READY;
               norm_d  = 1'b0;
            end
         end
         S_READY:
         begin
            if (if_ok & if_rewind & ~load_point)
            begin
               state_d = S_REWIND;
               fast_d  = 1'b1;
               rev_d   = 1'b1;
            end
            else if (panel_ok & rewind_btn & ~test_go)
            begin
               state_d = load_point ? S_UNWIND : S_REWIND;
               fast_d  = 1'b1;
               rev_d   = 1'b1;
            end
            else if (want_run)
            begin
               if (moving(norm_q, fast_q))
               begin
                  norm_d = norm_q;
                  fast_d = fast_q;
                  rev_d  = rev_q;
               end
               else
               begin
                  norm_d = ~want_fast;
                  fast_d = want_fast;
                  rev_d  = want_rev;
               end
            end
         end
         S_REWIND, S_UNWIND:
         begin
            if (state_q == S_REWIND && load_point)
               state_d = S_READY;
            else if (tension_lost)
            begin
               state_d = S_UNLOADED;
               load_d  = 1'b0;
            end
            else
            begin
               fast_d = 1'b1;
               rev_d  = 1'b1;
            end
         end
         default:
         begin
            state_d = S_UNLOADED;
         end
      endcase
      // Tape gone: nothing left to drive, reload from scratch
      if (broken_tape)
      begin
         state_d = S_UNLOADED;
         load_d  = 1'b0;
         norm_d  = 1'b0;
         fast_d  = 1'b0;
         rev_d   = 1'b0;
      end
   end

   always_comb
   begin
      online_d = online_q;
      if (broken_tape | (online_q & (online_btn | (if_select & if_offline))))
         online_d = 1'b0;
      else if (~online_q & online_btn & at_ready & ~test_q)
         online_d = 1'b1;
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q  <= S_UNLOADED;
         load_q   <= 1'b0;
         online_q <= 1'b0;
         norm_q   <= 1'b0;
         fast_q   <= 1'b0;
         rev_q    <= 1'b0;
      end
      else
      begin
         state_q  <= state_d;
         load_q   <= load_d;
         online_q <= online_d;
         norm_q   <= norm_d;
         fast_q   <= fast_d;
         rev_q    <= rev_d;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         test_q <= 1'b0;
      else if (!tp_ok)
         test_q <= 1'b0;
      else if (tp_test)
         test_q <= 1'b1;
   end

   // ************************************************************
   // Write test pattern
   // ************************************************************
   // Divider restarts whenever the test write is dropped, so the
   // first strobe always comes one full period after the start
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_q    <= '0;
         strobe_q <= 1'b0;
         tdata_q  <= '0;
      end
      else
      begin
         cnt_q    <= (!tw_active || div_hit) ? '0 : cnt_q + 1'b1;
         strobe_q <= tw_active & div_hit;
         tdata_q  <= (tw_active & div_hit) ? '1 : '0;
      end
   end

   // ************************************************************
   // Register port
   // ************************************************************
   wire               wr_ctrl = bus_wr & (bus_addr == REG_CTRL);
   wire               rd_stat = bus_addr == REG_STATUS;
   wire               rd_ctrl = bus_addr == REG_CTRL;
   wire [DATA_W-1:0]  stat_w;
   assign stat_w = DATA_W'({load_q, rev_q, fast_q, norm_q, test_q,
                            wr_ok, busy_w, loaded_w, online_q});
   wire [DATA_W-1:0]  rd_word = !bus_rd ? '0 : rd_stat ? stat_w
                              : rd_ctrl ? DATA_W'(div_q) : '0;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         div_q   <= CTRL_RST;
         rdata_q <= '0;
      end
      else
      begin
         if (wr_ctrl)
            div_q <= bus_wdata[CTRL_DIV_W-1:0];
         rdata_q <= rd_word;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign bus_rdata          = rdata_q;
   assign run_normal_cmd     = norm_q & ~broken_tape;
   assign run_fast_cmd       = fast_q & ~norm_q & ~broken_tape;
   assign reverse_select_cmd = rev_q & ~broken_tape;
   assign servo_enable       = load_q & ~broken_tape;
   assign tape_running       = ramp_active;
   assign busy               = busy_w;
   assign online             = online_q;
   assign rewinding          = rew_w;
   assign load_point_out     = load_point;
   assign tape_end_out       = tape_end_marker;
   assign load_lamp          = load_q;
   assign write_ready        = wr_ok;
   assign write_drive_on     = wr_ok;
   assign erase_drive_on     = wr_ok;
   assign write_lamp         = wr_ok;
   assign read_lamp          = loaded_w & ~rew_w & ~wr_ok;
   assign unit_selected      = sel_w;
   assign amp_write_en       = sel_w & wr_ok;
   assign amp_read_en        = sel_w;
   assign test_mode          = test_q;
   assign test_strobe        = strobe_q;
   assign test_data          = tdata_q;

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   a_iface_ignored: assert property (
      (at_ready && !online_q && !test_q && !norm_q && !fast_q) |=> !norm_q)
      else $error("motion started without interlocks");
   a_speed_exclusive: assert property (
      !(run_normal_cmd && run_fast_cmd))
      else $error("normal and fast both active");
   a_load_start: assert property (
      (state_q == S_UNLOADED && panel_ok && load_btn && !load_q)
      |=> (state_q == S_LOAD && load_q && norm_q))
      else $error("load did not start");
   a_write_perm: assert property (
      write_ready |-> (!file_protect && !busy && !reverse_select_cmd))
      else $error("write permitted against interlock");
   a_busy_seek: assert property (
      (state_q == S_LOAD || rewinding) |-> busy)
      else $error("busy missing");
   a_broken_stop: assert property (
      broken_tape |-> (!servo_enable && !run_normal_cmd && !run_fast_cmd
                       && !write_ready) ##1 (state_q == S_UNLOADED))
      else $error("broken tape not handled");
   a_rewind_stop: assert property (
      (state_q == S_REWIND && load_point && !broken_tape)
      |=> (state_q == S_READY && !fast_q && !rev_q))
      else $error("rewind passed load point");
   a_load_seek: assert property (
      (state_q == S_LOAD && load_point && !rewind_btn && !broken_tape)
      |=> (!norm_q && state_q == S_READY))
      else $error("load did not stop at load point");
   a_online_panel: assert property (
      (online_q && at_ready) |=> (state_q != S_UNWIND && state_q != S_LOAD))
      else $error("panel acted while online");
   a_test_gate: assert property (
      (online_q || !tp_stop) |=> !test_q)
      else $error("test mode outside offline stop");
   a_unwind_hold: assert property (
      (state_q == S_UNWIND && !tension_lost && !broken_tape)
      |=> (state_q == S_UNWIND && fast_q && rev_q))
      else $error("unwind interrupted");

   c_load_done: cover property (state_q == S_LOAD ##1 state_q == S_READY);
   c_rewind_done: cover property (state_q == S_REWIND ##1 state_q == S_READY);
   c_test_write: cover property (test_strobe);

endmodule

// File: sim/tb.sv
`timescale 1ns/1ps
module tb;
   import ttm_pkg::*;
   logic              ref_clk = 1'h0, rst_n = 1'h0, bus_wr = 1'h0, bus_rd = 1'h0;
   logic [ADDR_W-1:0] bus_addr = 8'h0;
   logic [DATA_W-1:0] bus_wdata = 32'h0, bus_rdata;
   logic [2:0]        op = 3'h0;
   logic [3:0]        btn = 4'h0;
   logic              if_select, if_run, if_reverse, if_rewind, if_offline;
   logic              load_btn, online_btn, rewind_btn, tp_test, tp_stop = 1'h0;
   logic              tp_fwd = 1'h0, tp_rev = 1'h0, tp_fast = 1'h0, tp_write = 1'h0;
   logic              file_protect = 1'h1, load_point = 1'h0, tape_end_marker = 1'h0;
   logic              broken_tape = 1'h0, tension_lost = 1'h0, ramp_active = 1'h0;
   logic              run_normal_cmd, run_fast_cmd, reverse_select_cmd, servo_enable;
   logic              tape_running, busy, online, rewinding, load_point_out, tape_end_out;
   logic              load_lamp, write_ready, write_drive_on, erase_drive_on, write_lamp;
   logic              read_lamp, unit_selected, amp_write_en, amp_read_en, test_mode;
   logic              test_strobe;
   logic [8:0]        test_data;
   int                mismatches = 0, checked = 0, n;

   assign {tp_test, rewind_btn, online_btn, load_btn} = btn;
   always #10 ref_clk = ~ref_clk;

   ttm_transport #(.TRACKS(9)) u_ttm_transport (
      .ref_clk(ref_clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .if_select(if_select),
      .if_run(if_run), .if_reverse(if_reverse), .if_rewind(if_rewind),
      .if_offline(if_offline), .load_btn(load_btn), .online_btn(online_btn),
      .rewind_btn(rewind_btn), .tp_stop(tp_stop), .tp_test(tp_test), .tp_fwd(tp_fwd),
      .tp_rev(tp_rev), .tp_fast(tp_fast), .tp_write(tp_write),
      .file_protect(file_protect), .load_point(load_point),
      .tape_end_marker(tape_end_marker), .broken_tape(broken_tape),
      .tension_lost(tension_lost), .ramp_active(ramp_active),
      .run_normal_cmd(run_normal_cmd), .run_fast_cmd(run_fast_cmd),
      .reverse_select_cmd(reverse_select_cmd), .servo_enable(servo_enable),
      .tape_running(tape_running), .busy(busy), .online(online), .rewinding(rewinding),
      .load_point_out(load_point_out), .tape_end_out(tape_end_out),
      .load_lamp(load_lamp), .write_ready(write_ready), .write_drive_on(write_drive_on),
      .erase_drive_on(erase_drive_on), .write_lamp(write_lamp), .read_lamp(read_lamp),
      .unit_selected(unit_selected), .amp_write_en(amp_write_en),
      .amp_read_en(amp_read_en), .test_mode(test_mode), .test_strobe(test_strobe),
      .test_data(test_data));
   ttm_fmt_model u_ttm_fmt_model (
      .ref_clk(ref_clk), .rst_n(rst_n), .op(op), .if_select(if_select), .if_run(if_run),
      .if_reverse(if_reverse), .if_rewind(if_rewind), .if_offline(if_offline));

   // ************************************************************
   // Access tasks
   // ************************************************************
   // Checks run just after an edge, so they see the cycle that just ended
   task automatic tick(input int k);
      repeat (k) @(posedge ref_clk);
   endtask
   task automatic ck(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         $display("Error %s expected %h seen %h", nm, exp, got);
         mismatches++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus_addr  <= a;
      bus_wdata <= d;
      bus_wr    <= 1'h1;
      tick(1);
      bus_wr    <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus_addr <= a;
      bus_rd   <= 1'h1;
      tick(1);
      bus_rd   <= 1'h0;
      tick(1);
      ck("rdata", bus_rdata, e);
   endtask
   // Buttons are one-cycle pulses; the answer shows in the cycle after the press
   task automatic press(input logic [3:0] b);
      btn <= b;
      tick(1);
      btn <= 4'h0;
      tick(2);
   endtask
   // Link commands pass the partner register, hence the longer wait
   task automatic cmd(input logic [2:0] c);
      op <= c;
      tick(1);
      op <= 3'h1;
      tick(4);
   endtask
   task automatic wstr(output int c);
      c = 0;
      while (test_strobe !== 1'h1 && c < 300)
      begin
         tick(1);
         c++;
      end
   endtask
   task automatic results;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   always @(posedge ref_clk)
      if (rst_n && run_normal_cmd && run_fast_cmd)
         ck("speeds", 1, 0);

   initial
   begin
      tick(20000);
      mismatches++;
      results;
   end

   // ************************************************************
   // Tests
   // ************************************************************
   initial
   begin
      tick(10);
      rst_n <= 1'h1;
      op    <= 3'h1;
      tick(1);
      rd(REG_CTRL, {16'h0, CTRL_RST});
      wr(REG_STATUS, 32'hffff_ffff);
      rd(REG_STATUS, 32'h0);
      rd(8'h20, 32'h0);
      press(4'h1);
      ck("rn", run_normal_cmd, 1);
      ck("busy", busy, 1);
      ck("servo", servo_enable, 1);
      ck("llamp", load_lamp, 1);
      ramp_active <= 1'h1;
      tick(2);
      ck("run", tape_running, 1);
      load_point  <= 1'h1;
      ramp_active <= 1'h0;
      tick(2);
      ck("rn", run_normal_cmd, 0);
      ck("busy", busy, 0);
      ck("rlamp", read_lamp, 1);
      ck("lpo", load_point_out, 1);
      op <= 3'h2;
      tick(4);
      ck("rn", run_normal_cmd, 0);
      op <= 3'h1;
      tick(2);
      press(4'h2);
      ck("onl", online, 1);
      ck("amprd", amp_read_en, 1);
      press(4'h4);
      ck("rwd", rewinding, 0);
      file_protect <= 1'h0;
      op           <= 3'h2;
      tick(4);
      ck("wrdy", write_ready, 1);
      ck("wdrv", write_drive_on, 1);
      ck("edrv", erase_drive_on, 1);
      ck("wlamp", write_lamp, 1);
      ck("ampwr", amp_write_en, 1);
      load_point      <= 1'h0;
      tape_end_marker <= 1'h1;
      tick(2);
      ck("rn", run_normal_cmd, 1);
      ck("teo", tape_end_out, 1);
      file_protect <= 1'h1;
      tick(2);
      ck("wrdy", write_ready, 0);
      file_protect <= 1'h0;
      op           <= 3'h1;
      tick(4);
      ck("rn", run_normal_cmd, 0);
      op <= 3'h3;
      tick(4);
      ck("rev", reverse_select_cmd, 1);
      ck("wrdy", write_ready, 0);
      op <= 3'h0;
      tick(4);
      ck("sel", unit_selected, 0);
      cmd(3'h4);
      ck("rf", run_fast_cmd, 1);
      ck("busy", busy, 1);
      op <= 3'h2;
      tick(4);
      ck("rn", run_normal_cmd, 0);
      op <= 3'h1;
      tick(1);
      load_point <= 1'h1;
      tick(2);
      ck("rf", run_fast_cmd, 0);
      cmd(3'h4);
      ck("rwd", rewinding, 0);
      cmd(3'h5);
      ck("onl", online, 0);
      press(4'h4);
      load_point <= 1'h0;
      tick(4);
      ck("rwd", rewinding, 1);
      tension_lost <= 1'h1;
      tick(2);
      ck("rwd", rewinding, 0);
      tension_lost <= 1'h0;
      press(4'h1);
      // Marker already passed during the load search: rewind back to it
      press(4'h4);
      ck("rwd", rewinding, 1);
      load_point <= 1'h1;
      tick(3);
      press(4'h8);
      ck("test", test_mode, 0);
      tp_stop <= 1'h1;
      tp_fwd  <= 1'h1;
      tick(3);
      ck("rn", run_normal_cmd, 0);
      tp_fwd <= 1'h0;
      press(4'h8);
      ck("test", test_mode, 1);
      load_point <= 1'h0;
      // Stop between speeds, since a speed change while moving is refused
      for (int i = 0; i < 4; i++)
      begin
         tp_fast <= i[0];
         tp_rev  <= i[1];
         tp_fwd  <= !i[1];
         tick(3);
         ck("rn", run_normal_cmd, !i[0]);
         ck("rf", run_fast_cmd, i[0]);
         ck("rev", reverse_select_cmd, i[1]);
         tp_rev <= 1'h0;
         tp_fwd <= 1'h0;
         tick(3);
      end
      tp_fast <= 1'h0;
      tp_fwd  <= 1'h1;
      tick(3);
      tp_fast <= 1'h1;
      tick(3);
      ck("rn", run_normal_cmd, 1);
      tp_fast <= 1'h0;
      wr(REG_CTRL, 32'h4);
      rd(REG_CTRL, 32'h4);
      tp_write <= 1'h1;
      wstr(n);
      ck("tdat", test_data, 32'h1ff);
      ck("tstb", test_strobe, 1);
      tick(1);
      ck("tdat", test_data, 0);
      wstr(n);
      ck("period", n + 1, 4);
      broken_tape <= 1'h1;
      tick(1);
      ck("rn", run_normal_cmd, 0);
      ck("servo", servo_enable, 0);
      ck("wrdy", write_ready, 0);
      results;
   end
endmodule

// File: sim/ttm_fmt_model.sv
`timescale 1ns/1ps
// ************************************************************
// Formatter side of the motion link
// ************************************************************
module ttm_fmt_model
(
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   input  wire logic [2:0] op,
   output logic            if_select,
   output logic            if_run,
   output logic            if_reverse,
   output logic            if_rewind,
   output logic            if_offline
);
   // Op 0 drops select, 1 idles selected, 2 and 3 run, 4 rewind, 5 offline
   // Registered, so every request lags op by one cycle like a real cable
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         {if_select, if_run, if_reverse, if_rewind, if_offline} <= 5'h0;
      end
      else
      begin
         if_select  <= op != 3'h0;
         if_run     <= op == 3'h2 || op == 3'h3;
         if_reverse <= op == 3'h3;
         if_rewind  <= op == 3'h4;
         if_offline <= op == 3'h5;
      end
   end
endmodule
